/* File: ocr_pkg.sv */
// ocr_pkg: shared constants, codes and carriers of the oscillator control block.
// assumes a 32-bit AHB-Lite register bus and word-aligned registers.
package ocr_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_KEY = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0C;

	////////////////////////////////////////////////////////////////////////////////
	// oscillator_control field positions
	localparam int CUR_LO = 12;
	localparam int NEW_LO = 8;
	localparam int CLOCK_SELECTION_LOCK_B = 7;
	localparam int PINLOCK_B = 6;
	localparam int PLLLOCK_B = 5;
	localparam int UNIMP_B = 4;
	localparam int FAIL_B = 3;
	localparam int POSC_B = 2;
	localparam int SECONDARY_OSC_B = 1;
	localparam int SWREQ_B = 0;

	// reset values of software bits
	localparam logic CLOCK_SELECTION_LOCK_RST = 1'b0;
	localparam logic PINLOCK_RST = 1'b0;
	localparam logic POSC_RST = 1'b0;
	localparam logic SECONDARY_OSC_RST = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// unlock keys, written in this order to the key register
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;

	// cycles of the new source before the switch is made
	localparam int SWITCH_WAIT = 10;

	// interrupt status and mask layout
	localparam int IRQ_DONE = 0;
	localparam int IRQ_FAIL = 1;
	localparam int IRQ_ABORT = 2;
	localparam int IRQ_W = 3;

	////////////////////////////////////////////////////////////////////////////////
	// clock source encodings
	typedef enum logic [2:0] {
		SRC_FRC = 3'h0,
		SRC_FRC_PLL = 3'h1,
		SRC_PRI = 3'h2,
		SRC_PRI_PLL = 3'h3,
		SRC_SEC = 3'h4,
		SRC_LOW_POWER_RC = 3'h5,
		SRC_FRC_DIV16 = 3'h6,
		SRC_FRC_POST = 3'h7
	} ocr_src_t;

	// configuration straps, stable from before reset release
	typedef struct packed {
		logic [2:0] initSrc;
		logic failSafe;
		logic oneShot;
	} ocr_cfg_t;

	// controls towards the oscillators and pin mapping
	typedef struct packed {
		logic [2:0] curSrc;
		logic primaryRun;
		logic secondaryEnable;
		logic pinMappingLock;
		logic switchBusy;
	} ocr_osc_t;

	// sources that run through the pll
	function automatic logic ocr_uses_pll(input logic [2:0] s);
		return (s == SRC_PRI_PLL) || (s == SRC_FRC_PLL);
	endfunction : ocr_uses_pll

endpackage : ocr_pkg

/* File: ocr_sync.sv */
// ocr_sync: two-flop synchroniser for a group of independent levels.
// assumes each bit is a level held long enough to be seen; no bus coherence.
`timescale 1ns/10ps
module ocr_sync
	import ocr_pkg::*;
#(
	parameter int WIDTH = 3
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// levels
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	if (WIDTH < 1) begin : g_bad_width
		$error("ocr_sync needs WIDTH of at least one");
	end

	logic [WIDTH-1:0] stage1;

	// first stage is read only by the second
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			stage1 <= '0;
			dout <= '0;
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end

endmodule : ocr_sync

/* File: ocr_switch_seq.sv */
// ocr_switch_seq: clock switch sequencer, holds the current source field.
// assumes start is a one-cycle pulse and srcTick marks one new-source cycle.
`timescale 1ns/10ps
module ocr_switch_seq
	import ocr_pkg::*;
#(
	parameter int WAIT_CYCLES = SWITCH_WAIT
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [2:0] initSrc,
	// request
	input wire logic start,
	input wire logic [2:0] target,
	// source status, synchronised
	input wire logic srcTick,
	input wire logic pllReady,
	// results
	output logic busy,
	output logic done,
	output logic abort,
	output logic [2:0] curSrc
);

	if (WAIT_CYCLES < 1 || WAIT_CYCLES > 255) begin : g_bad_wait
		$error("ocr_switch_seq WAIT_CYCLES out of range");
	end

	typedef enum logic [1:0] {
		SQ_IDLE = 2'b00,
		SQ_READY = 2'b01,
		SQ_COUNT = 2'b11,
		SQ_DONE = 2'b10
	} ocr_sq_t;

	localparam logic [7:0] LAST = 8'(WAIT_CYCLES - 1);

	ocr_sq_t state;
	logic [7:0] cnt;
	logic [2:0] goal;

	assign busy = (state != SQ_IDLE);

	////////////////////////////////////////////////////////////////////////////////
	// sequence: wait for source, count its cycles, then switch
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state <= SQ_IDLE;
			cnt <= '0;
			goal <= '0;
			done <= 1'b0;
			abort <= 1'b0;
			curSrc <= initSrc; // loaded from straps
		end else begin
			done <= 1'b0;
			abort <= 1'b0;
			case (state)
				SQ_IDLE: begin
					if (start && target == curSrc) begin
						abort <= 1'b1;
					end else if (start) begin
						goal <= target;
						state <= SQ_READY;
					end
				end
				SQ_READY: begin
					// pll sources wait for lock first
					cnt <= '0;
					if (!ocr_uses_pll(goal) || pllReady) begin
						state <= SQ_COUNT;
					end
				end
				SQ_COUNT: begin
					if (srcTick && cnt == LAST) begin
						curSrc <= goal;
						done <= 1'b1;
						state <= SQ_DONE;
					end else if (srcTick) begin
						cnt <= cnt + 8'h01;
					end
				end
				default: begin
					state <= SQ_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence s_last_tick;
		state == SQ_COUNT && srcTick && cnt == LAST;
	endsequence

	a_switch_after_wait: assert property (s_last_tick |=> done && curSrc == $past(goal))
		else $error("switch not made after wait count");
	a_redundant_abort: assert property (start && !busy && target == curSrc |=> abort && !busy)
		else $error("redundant switch not aborted");
	a_done_needs_count: assert property ($rose(done) |-> $past(state) == SQ_COUNT)
		else $error("switch done without counting");

endmodule : ocr_switch_seq

/* File: ocr_osc_ctrl.sv */
// ocr_osc_ctrl: oscillator control register with its switch sequencer,
// reached over an AHB-Lite slave port with a write unlock and an interrupt.
// assumes one master, single word transfers, and straps stable around reset.
// Notes on behaviour
// - new source field encodes eight clock sources, 111 down to 000.
// - new source field resets from the initial source strap.
// - with fail-safe strap set, selection lock blocks source changes and switching.
// - with fail-safe strap clear, source selection is never locked.
// - pin mapping lock bit is held here; one means active.
// - pin mapping lock changes only after the unlock sequence.
// - with one-shot strap set, a set pin lock stays until reset.
// - pll lock status is one when locked and zero otherwise.
// - pll lock status clears on a valid switch and on non-pll sources.
// - unimplemented bit four reads as zero.
// - clock fail flag sets when the monitor reports a failure.
// - primary oscillator keep bit keeps it running in sleep.
// - secondary oscillator enable bit drives the 32 kHz oscillator.
// - setting switch request starts a switch; it reads zero when done.
// - a request to the current source is aborted and cleared.
// - after ten new-source cycles the switch updates the current source.
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module ocr_osc_ctrl
	import ocr_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// configuration straps
	input wire ocr_cfg_t cfg,
	// oscillator status from other domains
	input wire logic newSrcClk,
	input wire logic pllLocked,
	input wire logic clockFail,
	// power state, same clock
	input wire logic sleepMode,
	// oscillator controls and interrupt
	output ocr_osc_t osc,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [2:0] syncIn;
	logic srcPrev;
	logic srcTick;
	logic pllSync;
	logic failSync;
	logic addrPhase;
	logic dWr;
	logic [7:0] dAddr;
	logic wrCtrl;
	logic wrKey;
	logic wrStat;
	logic wrMask;
	logic unlockStage;
	logic unlockArmed;
	logic ctrlOk;
	logic selLocked;
	logic [2:0] newSrc;
	logic clock_selection_lock;
	logic pinLock;
	logic lockStatus;
	logic cfFlag;
	logic poscKeep;
	logic secondary_osc_enable;
	logic swReq;
	logic startPulse;
	logic reqSet;
	logic seqBusy;
	logic seqDone;
	logic seqAbort;
	logic [2:0] curSrc;
	logic [15:0] ctrlWord;
	logic [31:0] readMux;
	logic [IRQ_W-1:0] intStat;
	logic [IRQ_W-1:0] intMask;
	logic [IRQ_W-1:0] events;
	logic primaryRun;
	logic next_lock;

	////////////////////////////////////////////////////////////////////////////////
	// synchronise the asynchronous oscillator levels
	ocr_sync #(
		.WIDTH(3)
	) u_sync (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.din({newSrcClk, pllLocked, clockFail}),
		.dout(syncIn)
	);

	assign pllSync = syncIn[1];
	assign failSync = syncIn[0];

	// new-source rising edge; source must run below half of sys_clk
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			srcPrev <= 1'b0;
		end else begin
			srcPrev <= syncIn[2];
		end
	end

	assign srcTick = syncIn[2] & ~srcPrev;

	////////////////////////////////////////////////////////////////////////////////
	// ahb-lite slave: zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addrPhase = hsel & htrans[1] & hready;

	// hold the write address for its data phase
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			dWr <= 1'b0;
			dAddr <= 8'h00;
		end else if (hready) begin
			dWr <= addrPhase & hwrite;
			dAddr <= haddr[7:0];
		end
	end

	assign wrCtrl = dWr && (dAddr == OFS_CTRL);
	assign wrKey = dWr && (dAddr == OFS_KEY);
	assign wrStat = dWr && (dAddr == OFS_STAT);
	assign wrMask = dWr && (dAddr == OFS_MASK);

	// control word, bit four and top bit zero
	assign ctrlWord = {1'b0, curSrc, 1'b0, newSrc, clock_selection_lock, pinLock, lockStatus,
		1'b0, cfFlag, poscKeep, secondary_osc_enable, swReq};

	// read decode, unmapped offsets read zero
	always_comb begin
		readMux = 32'h0000_0000;
		if (haddr[7:0] == OFS_CTRL) begin
			readMux = {16'h0000, ctrlWord};
		end else if (haddr[7:0] == OFS_KEY) begin
			readMux = {30'h0000_0000, unlockArmed, unlockStage};
		end else if (haddr[7:0] == OFS_STAT) begin
			readMux = {29'h0000_0000, intStat};
		end else if (haddr[7:0] == OFS_MASK) begin
			readMux = {29'h0000_0000, intMask};
		end
	end

	// read data sampled in the address phase, stands for the data phase
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			hrdata <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			hrdata <= readMux;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// unlock: two keys in order arm exactly one control write
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			unlockStage <= 1'b0;
			unlockArmed <= 1'b0;
		end else if (wrKey) begin
			unlockStage <= (hwdata[7:0] == KEY_FIRST);
			unlockArmed <= unlockStage && (hwdata[7:0] == KEY_SECOND);
		end else if (wrCtrl) begin
			unlockStage <= 1'b0;
			unlockArmed <= 1'b0;
		end
	end

	// control writes take effect only when unlocked
	assign ctrlOk = wrCtrl & unlockArmed;
	// lock counts only with the fail-safe strap
	assign selLocked = cfg.failSafe & clock_selection_lock;

	////////////////////////////////////////////////////////////////////////////////
	// new source field, strap at reset, frozen while switching
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			newSrc <= cfg.initSrc;
		end else if (ctrlOk && !selLocked && !swReq) begin
			newSrc <= hwdata[NEW_LO +: 3];
		end
	end

	// plain software bits: selection lock and oscillator enables
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			clock_selection_lock <= CLOCK_SELECTION_LOCK_RST;
			poscKeep <= POSC_RST;
			secondary_osc_enable <= SECONDARY_OSC_RST;
		end else if (ctrlOk) begin
			clock_selection_lock <= hwdata[CLOCK_SELECTION_LOCK_B];
			poscKeep <= hwdata[POSC_B];
			secondary_osc_enable <= hwdata[SECONDARY_OSC_B];
		end
	end

	// pin lock, unlocked writes, one-shot stays set
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			pinLock <= PINLOCK_RST;
		end else if (ctrlOk && (hwdata[PINLOCK_B] || !(cfg.oneShot && pinLock))) begin
			pinLock <= hwdata[PINLOCK_B];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// switch request, cleared by the sequencer
	assign reqSet = ctrlOk && hwdata[SWREQ_B] && !selLocked && !swReq;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			swReq <= 1'b0;
			startPulse <= 1'b0;
		end else begin
			startPulse <= reqSet;
			if (seqDone || seqAbort) begin
				swReq <= 1'b0;
			end else if (reqSet) begin
				swReq <= 1'b1;
			end
		end
	end

	ocr_switch_seq #(
		.WAIT_CYCLES(SWITCH_WAIT)
	) u_seq (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.initSrc(cfg.initSrc),
		.start(startPulse),
		.target(newSrc),
		.srcTick(srcTick),
		.pllReady(pllSync),
		.busy(seqBusy),
		.done(seqDone),
		.abort(seqAbort),
		.curSrc(curSrc)
	);

	////////////////////////////////////////////////////////////////////////////////
	// pll lock status, dropped on switching or non-pll source
	// a redundant request is no switch, so it leaves the status standing
	assign next_lock = pllSync && ocr_uses_pll(curSrc) && !seqBusy
		&& !(startPulse && newSrc != curSrc);

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			lockStatus <= 1'b0;
		end else begin
			lockStatus <= next_lock;
		end
	end

	// clock fail flag, a failure wins over the switch clear
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			cfFlag <= 1'b0;
		end else if (failSync) begin
			cfFlag <= 1'b1;
		end else if (startPulse && newSrc != curSrc) begin
			cfFlag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// oscillator controls, registered except switch busy, which is decoded from the sequencer state
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			primaryRun <= 1'b1;
		end else begin
			primaryRun <= !sleepMode || poscKeep;
		end
	end

	assign osc.curSrc = curSrc;
	assign osc.primaryRun = primaryRun;
	assign osc.secondaryEnable = secondary_osc_enable;
	assign osc.pinMappingLock = pinLock;
	assign osc.switchBusy = seqBusy;

	////////////////////////////////////////////////////////////////////////////////
	// interrupt: sticky events, write one to clear, set wins
	always_comb begin
		events = '0;
		events[IRQ_DONE] = seqDone;
		events[IRQ_FAIL] = failSync;
		events[IRQ_ABORT] = seqAbort;
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			intStat <= '0;
		end else if (wrStat) begin
			intStat <= (intStat & ~hwdata[IRQ_W-1:0]) | events;
		end else begin
			intStat <= intStat | events;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			intMask <= '0;
		end else if (wrMask) begin
			intMask <= hwdata[IRQ_W-1:0];
		end
	end

	// level output, high while any unmasked event is pending
	assign irq = |(intStat & intMask);

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence s_valid_switch;
		startPulse && newSrc != curSrc;
	endsequence

	// keys two idle cycles apart, as a single-transfer master issues them
	sequence s_key_pair;
		wrKey && hwdata[7:0] == KEY_FIRST ##1 (!wrKey && !wrCtrl) [*2]
			##1 wrKey && hwdata[7:0] == KEY_SECOND;
	endsequence

	a_reserved_bits_zero: assert property (ctrlWord[UNIMP_B] == 1'b0 && ctrlWord[15] == 1'b0)
		else $error("unimplemented control bit reads one");
	a_locked_no_request: assert property ($rose(swReq) |-> $past(!selLocked && unlockArmed))
		else $error("switch request set while locked");
	a_unlocked_request: assert property (ctrlOk && hwdata[SWREQ_B] && !cfg.failSafe
		&& !swReq |=> swReq)
		else $error("unlocked request ignored");
	a_pin_needs_key: assert property ($changed(pinLock) |-> $past(unlockArmed && wrCtrl))
		else $error("pin lock changed without unlock");
	a_pin_one_shot: assert property (pinLock && cfg.oneShot |=> pinLock)
		else $error("one-shot pin lock cleared");
	a_keys_arm: assert property (s_key_pair |=> unlockArmed)
		else $error("key pair did not unlock");
	a_lock_drop_switch: assert property (s_valid_switch |=> !lockStatus [*2])
		else $error("pll lock status kept during switch");
	a_lock_non_pll: assert property (!ocr_uses_pll(curSrc) |=> !lockStatus)
		else $error("pll lock status on non-pll source");
	a_lock_follows_pll: assert property (pllSync && ocr_uses_pll(curSrc) && !seqBusy
		&& !startPulse |=> lockStatus)
		else $error("pll lock status missing");
	a_fail_sets_flag: assert property (failSync |=> cfFlag && intStat[IRQ_FAIL])
		else $error("clock failure not flagged");
	a_request_clears: assert property (seqDone || seqAbort |=> !swReq)
		else $error("switch request not cleared");
	a_redundant_clear: assert property (startPulse && newSrc == curSrc |=> ##1 !swReq)
		else $error("redundant request not cleared");
	a_sleep_keep: assert property (sleepMode && !poscKeep |=> !primaryRun)
		else $error("primary oscillator kept in sleep");
	a_sec_enable: assert property ((ctrlOk |=> secondary_osc_enable == $past(hwdata[SECONDARY_OSC_B]))
		and osc.secondaryEnable == secondary_osc_enable)
		else $error("secondary enable not following register");

endmodule : ocr_osc_ctrl

/* File: ocr_osc_ctrl_test.sv */
// ocr_osc_ctrl_test: self-checking bench for the oscillator control block.
// assumes ocr_pkg is compiled first; the bench is the only bus master.
`timescale 1ns/10ps
module ocr_osc_ctrl_test
	import ocr_pkg::*;
;
	// bus, straps and oscillator status
	logic sys_clk, rstn, hsel, hwrite, hreadyout, hresp, irq;
	logic newSrcClk, pllLocked, clockFail, sleepMode;
	logic [31:0] haddr, hwdata, hrdata, rd, seed;
	logic [1:0] htrans;
	logic [2:0] hsize;
	ocr_cfg_t cfg;
	ocr_osc_t osc;
	// counters and the behavioural register model
	int failures, compares, cycles, i, tgt;
	int mCur, mNew, mClk, mPin, mPll, mCf, mKeep, mSec, mReq, mStat, mMask;
	bit fs, os;

	ocr_osc_ctrl dut_u (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.cfg(cfg), .newSrcClk(newSrcClk), .pllLocked(pllLocked), .clockFail(clockFail),
		.sleepMode(sleepMode), .osc(osc), .irq(irq));

	////////////////////////////////////////////////////////////////////////////////
	// clock of 40 ns
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// new source runs free at a quarter rate, slow enough to be counted; hang guard
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		newSrcClk <= cycles[1];
		if (cycles == 30000) begin
			failures = failures + 1;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	// expected control word; bit 4 and the upper bits stay zero
	function automatic logic [31:0] ctrlWord();
		return {17'h0, mCur[2:0], 1'b0, mNew[2:0], mClk[0], mPin[0], mPll[0], 1'b0,
			mCf[0], mKeep[0], mSec[0], mReq[0]};
	endfunction : ctrlWord

	task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk_reg

	task automatic chk_pin(input string n, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %b seen %b", n, e, g);
		end
	endtask : chk_pin

	// one single word transfer; read data taken at the end of the data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk_pin("hresp", 1'b0, hresp);
	endtask : bus

	// pins sampled mid-cycle, away from register updates
	task automatic chkPins();
		@(negedge sys_clk);
		chk_pin("irq", (mStat & mMask) != 0, irq);
		chk_reg("curSrc", mCur, {29'h0, osc.curSrc});
		chk_pin("pinLock", mPin[0], osc.pinMappingLock);
		chk_pin("secEnable", mSec[0], osc.secondaryEnable);
		chk_pin("primaryRun", !sleepMode || mKeep[0], osc.primaryRun);
		chk_pin("switchBusy", mReq != 0 && mNew != mCur, osc.switchBusy);
	endtask : chkPins

	// poll until the request bit falls, then settle the model
	task automatic waitSwitch();
		int n;
		n = 0;
		// a valid request keeps the sequencer busy from the edge after the write
		@(posedge sys_clk);
		chkPins();
		do begin
			bus(1'b0, OFS_CTRL, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 200);
		chk_pin("switchDone", 1'b1, n < 200);
		// lock status returns an edge after the request drops, so read once more
		bus(1'b0, OFS_CTRL, 32'h0);
		if (mNew == mCur) mStat |= 4;
		else begin
			mStat |= 1;
			mCur = mNew;
			mCf = 0;
		end
		mReq = 0;
		mPll = (mCur == 1 || mCur == 3);
		chk_reg("ctrl", ctrlWord(), rd);
		bus(1'b0, OFS_STAT, 32'h0);
		chk_reg("status", mStat, rd);
	endtask : waitSwitch

	// control write, optionally behind the two key writes
	task automatic setCtrl(input int nw, cl, pl, kp, sc, rq, input bit unl);
		bit lk;
		lk = fs && mClk;
		if (unl) begin
			bus(1'b1, OFS_KEY, {24'h0, KEY_FIRST});
			bus(1'b1, OFS_KEY, {24'h0, KEY_SECOND});
		end
		bus(1'b1, OFS_CTRL, {21'h0, 3'(nw), 1'(cl), 1'(pl), 3'h0, 1'(kp), 1'(sc), 1'(rq)});
		if (unl) begin
			if (!lk) mNew = nw;
			mClk = cl;
			if (!(os && mPin)) mPin = pl;
			mKeep = kp;
			mSec = sc;
			mReq = rq && !lk;
		end
		if (mReq) waitSwitch();
		else begin
			bus(1'b0, OFS_CTRL, 32'h0);
			chk_reg("ctrl", ctrlWord(), rd);
		end
		chkPins();
	endtask : setCtrl

	task automatic doReset(input bit f, input bit o);
		@(posedge sys_clk);
		rstn <= 1'b0;
		seed = xs(seed);
		cfg <= {seed[2:0], f, o};
		fs = f;
		os = o;
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		mCur = seed[2:0];
		mNew = mCur;
		{mClk, mPin, mKeep, mSec, mReq, mCf, mStat, mMask} = '0;
		mPll = (mCur == 1 || mCur == 3);
		// let the synchronisers fill before the first access
		repeat (3) @(posedge sys_clk);
	endtask : doReset

	task automatic wrap_up();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////////////
	// main sequence: free switching first, then fail-safe and one-shot straps
	initial begin
		{rstn, hsel, haddr, htrans, hwrite, hwdata, cfg, clockFail, sleepMode} = '0;
		{failures, compares} = '0;
		hsize = 3'h2;
		pllLocked = 1'b1;
		seed = 32'h672A;
		doReset(1'b0, 1'b0);
		bus(1'b0, OFS_CTRL, 32'h0);
		chk_reg("ctrl", ctrlWord(), rd);
		chkPins();
		seed = xs(seed);
		bus(1'b1, 8'h10, seed);
		bus(1'b0, 8'h10, 32'h0);
		chk_reg("unmapped", 32'h0, rd);
		setCtrl(mNew, 0, 1, 1, 1, 0, 0);
		setCtrl(mNew, 1, 1, 1, 1, 0, 1);
		@(posedge sys_clk);
		sleepMode <= 1'b1;
		setCtrl(mNew, 1, 0, 0, 0, 0, 1);
		setCtrl(mNew, 1, 0, 1, 0, 0, 1);
		@(posedge sys_clk);
		sleepMode <= 1'b0;
		// failure seen through the monitor, then the interrupt path
		clockFail <= 1'b1;
		repeat (6) @(posedge sys_clk);
		clockFail <= 1'b0;
		repeat (4) @(posedge sys_clk);
		{mCf, mStat} = {32'd1, 32'd2};
		bus(1'b0, OFS_CTRL, 32'h0);
		chk_reg("ctrl", ctrlWord(), rd);
		chkPins();
		mMask = 7;
		bus(1'b1, OFS_MASK, 32'h7);
		chkPins();
		// every source in turn with the lock bit set; last step is redundant
		for (i = 0; i < 9; i++) begin
			tgt = (i < 8) ? (mCur + 1) % 8 : mCur;
			setCtrl(tgt, 1, 0, 1, 0, 0, 1);
			setCtrl(tgt, 1, 0, 1, 0, 1, 1);
			mStat = 0;
			bus(1'b1, OFS_STAT, 32'h7);
			chkPins();
			if (mPll) begin
				@(posedge sys_clk);
				pllLocked <= 1'b0;
				repeat (4) @(posedge sys_clk);
				mPll = 0;
				bus(1'b0, OFS_CTRL, 32'h0);
				chk_reg("ctrl", ctrlWord(), rd);
				pllLocked <= 1'b1;
				mPll = 1;
				repeat (4) @(posedge sys_clk);
			end
		end
		doReset(1'b1, 1'b1);
		setCtrl(mNew, 0, 1, 0, 1, 0, 1);
		setCtrl(mNew, 0, 0, 0, 1, 0, 1);
		setCtrl(mNew, 1, 1, 0, 1, 0, 1);
		tgt = (mCur + 3) % 8;
		setCtrl(tgt, 1, 1, 0, 1, 0, 1);
		setCtrl(tgt, 1, 1, 0, 1, 1, 1);
		setCtrl(mNew, 0, 1, 0, 1, 0, 1);
		setCtrl(tgt, 0, 1, 0, 1, 0, 1);
		setCtrl(tgt, 0, 1, 0, 1, 1, 1);
		wrap_up();
	end

endmodule : ocr_osc_ctrl_test
